// ===== hw/tco_channels.sv
// Timer channel output block: AXI4-Lite registers and four compare/PWM channels
//
// Summary of operation
// - Mode bits 0:1 select output compare
// - Compare match sets, clears or toggles output
// - Toggle mode holds level until first match
// - Match sets flag; interrupt only when enabled
// - Level-select 0:0 flags but leaves pin alone
// - mode_sel_b set selects edge-aligned PWM
// - Edge PWM width ends at match, flag there
// - Level 1:0: high at reload, low at match
// - Level X:1: low at reload, high at match
// - Match zero 0%, above modulo 100%, no flag
// - Nonzero start shifts edge PWM duty limits
// - center_align_select picks up-down center PWM
// - Center width and period twice span
// - Center mode flags both up and down matches
// - Center 1:0 high on down match, low up
// - Center zero/negative 0%, large match 100%
// - pair_merge_enable joins even and odd channels
// - Pair width is distance between matches
// - Pair flags set at own channel matches
// - Pair 1:0 output low at start, odd match
// - Pair polarity from even level bits; each channel's own 0:0 releases its pin
`timescale 1ns/10ps
module tco_channels (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [15:0] CNT_VALUE,
  input wire logic CNT_DOWN,
  input wire logic CNT_RELOAD,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [3:0] CH_OUT,
  output logic [3:0] CH_OE_N,
  output logic [3:0] CH_IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [4:0] cfg;
    logic [15:0] start;
    logic [15:0] modulo;
    tco_pkg::tco_chctl_t [3:0] ctl;
    logic [3:0][15:0] match;
    logic [3:0] flag;
    logic [3:0] out;
    logic [3:0] oe_n;
    logic [3:0] irq;
  } tco_state_t;

  // Pins start released so nothing is driven before software sets a level
  localparam tco_state_t RESET_STATE = '{
    cfg: tco_pkg::RST_CONFIG,
    start: tco_pkg::RST_START,
    modulo: tco_pkg::RST_MODULO,
    oe_n: 4'hf,
    default: '0
  };

  tco_state_t state_ff;
  tco_state_t nxt_state;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] addr);
    return addr < tco_pkg::OFS_CH_END;
  endfunction

  function automatic logic is_chan(input logic [7:0] addr);
    return (addr >= tco_pkg::OFS_CH_BASE) && (addr < tco_pkg::OFS_CH_END);
  endfunction

  function automatic logic [1:0] ch_of(input logic [7:0] addr);
    logic [2:0] w;
    w = addr[5:3] - tco_pkg::CH_WORD_BASE;
    return w[1:0];
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
      input logic [3:0] strb);
    logic [31:0] v;
    v = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        v[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return v;
  endfunction

  function automatic logic [31:0] read_reg(input tco_state_t st, input logic [7:0] addr);
    logic [31:0] v;
    logic [1:0] c;
    v = 32'h0000_0000;
    c = ch_of(addr);
    case ({addr[7:2], 2'h0})
      tco_pkg::OFS_CONFIG: v[tco_pkg::CFG_WIDTH-1:0] = st.cfg;
      tco_pkg::OFS_START: v[15:0] = st.start;
      tco_pkg::OFS_MODULO: v[15:0] = st.modulo;
      tco_pkg::OFS_STATUS: v[tco_pkg::STATUS_WIDTH-1:0] = st.flag;
      default:
      begin
        if (is_chan(addr))
        begin
          if (addr[2])
            v[15:0] = st.match[c];
          else
          begin
            v[tco_pkg::CTL_WIDTH-1:0] = st.ctl[c];
            v[tco_pkg::CTL_FLAG_BIT] = st.flag[c];
            v[tco_pkg::CTL_LEVEL_BIT] = st.out[c];
          end
        end
      end
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Channel evaluation, one instance per pair
  // ----------------------------------------------------------------
  logic [3:0] ev_out;
  logic [3:0] ev_drive;
  logic [3:0] ev_flag;

  for (genvar p = 0; p < tco_pkg::NUM_PAIRS; p++)
  begin : g_pair
    tco_pair_eval u_pair (
      .center_align_select(state_ff.cfg[tco_pkg::CFG_CENTER_BIT]),
      .pair_merge_enable(state_ff.cfg[tco_pkg::CFG_MERGE_LSB + p]),
      .dual_edge_capture_enable(state_ff.cfg[tco_pkg::CFG_DECAP_LSB + p]),
      .cnt_value(CNT_VALUE),
      .cnt_down(CNT_DOWN),
      .cnt_reload(CNT_RELOAD),
      .counter_start_value(state_ff.start),
      .modulo_value(state_ff.modulo),
      .even_ctl(state_ff.ctl[2*p]),
      .odd_ctl(state_ff.ctl[2*p+1]),
      .even_match(state_ff.match[2*p]),
      .odd_match(state_ff.match[2*p+1]),
      .cur_out(state_ff.out[2*p +: 2]),
      .nxt_out(ev_out[2*p +: 2]),
      .drive(ev_drive[2*p +: 2]),
      .set_flag(ev_flag[2*p +: 2])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic do_write;
  logic [3:0] flag_clr;
  logic [1:0] wr_ch;
  logic [31:0] wr_val;

  always_comb
  begin
    nxt_state = state_ff;
    flag_clr = 4'h0;
    wr_ch = ch_of(state_ff.aw_addr);
    wr_val = 32'h0000_0000;

    // Address and data are taken independently, in either order
    if (S_AXI_AWVALID && state_ff.awready)
    begin
      nxt_state.aw_have = 1'b1;
      nxt_state.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && state_ff.wready)
    begin
      nxt_state.w_have = 1'b1;
      nxt_state.w_data = S_AXI_WDATA;
      nxt_state.w_strb = S_AXI_WSTRB;
    end
    if (state_ff.bvalid && S_AXI_BREADY)
      nxt_state.bvalid = 1'b0;

    do_write = state_ff.aw_have && state_ff.w_have && !state_ff.bvalid;
    if (do_write)
    begin
      nxt_state.aw_have = 1'b0;
      nxt_state.w_have = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = is_mapped(state_ff.aw_addr) ? tco_pkg::RESP_OKAY : tco_pkg::RESP_SLVERR;
      wr_val = merge_bytes(read_reg(state_ff, state_ff.aw_addr), state_ff.w_data, state_ff.w_strb);
      case ({state_ff.aw_addr[7:2], 2'h0})
        tco_pkg::OFS_CONFIG: nxt_state.cfg = wr_val[tco_pkg::CFG_WIDTH-1:0];
        tco_pkg::OFS_START: nxt_state.start = wr_val[15:0];
        tco_pkg::OFS_MODULO: nxt_state.modulo = wr_val[15:0];
        // Write one to clear; only byte lane 0 counts and no readback merge is used
        tco_pkg::OFS_STATUS:
          flag_clr = state_ff.w_strb[0] ? state_ff.w_data[tco_pkg::STATUS_WIDTH-1:0] : 4'h0;
        default:
        begin
          if (is_chan(state_ff.aw_addr))
          begin
            if (state_ff.aw_addr[2])
              nxt_state.match[wr_ch] = wr_val[15:0];
            else
              nxt_state.ctl[wr_ch] = wr_val[tco_pkg::CTL_WIDTH-1:0];
          end
        end
      endcase
    end
    nxt_state.awready = !nxt_state.aw_have && !nxt_state.bvalid;
    nxt_state.wready = !nxt_state.w_have && !nxt_state.bvalid;

    // Read channel: one outstanding read, answered the cycle after it is taken
    if (state_ff.rvalid && S_AXI_RREADY)
      nxt_state.rvalid = 1'b0;
    if (S_AXI_ARVALID && state_ff.arready)
    begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata = read_reg(state_ff, S_AXI_ARADDR);
      nxt_state.rresp = is_mapped(S_AXI_ARADDR) ? tco_pkg::RESP_OKAY : tco_pkg::RESP_SLVERR;
    end
    nxt_state.arready = !nxt_state.rvalid;

    // Channel outputs and flags; a hardware set beats a software clear
    for (int i = 0; i < tco_pkg::NUM_CH; i++)
    begin
      nxt_state.flag[i] = (state_ff.flag[i] & ~flag_clr[i]) | ev_flag[i];
      if (ev_drive[i])
        nxt_state.out[i] = ev_out[i];
      nxt_state.oe_n[i] = ~ev_drive[i];
      nxt_state.irq[i] = nxt_state.flag[i] & state_ff.ctl[i].channel_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      state_ff <= RESET_STATE;
    else
      state_ff <= nxt_state;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY = state_ff.awready;
  assign S_AXI_WREADY = state_ff.wready;
  assign S_AXI_BRESP = state_ff.bresp;
  assign S_AXI_BVALID = state_ff.bvalid;
  assign S_AXI_ARREADY = state_ff.arready;
  assign S_AXI_RDATA = state_ff.rdata;
  assign S_AXI_RRESP = state_ff.rresp;
  assign S_AXI_RVALID = state_ff.rvalid;
  assign CH_OUT = state_ff.out;
  assign CH_OE_N = state_ff.oe_n;
  assign CH_IRQ = state_ff.irq;

endmodule

// ===== hw/tco_pkg.sv
// Package of constants and types for the timer channel output block
package tco_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int NUM_PAIRS = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_START = 8'h04;
  localparam logic [7:0] OFS_MODULO = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CH_BASE = 8'h10;
  localparam logic [7:0] OFS_CH_END = 8'h30;
  localparam logic [2:0] CH_WORD_BASE = 3'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_CENTER_BIT = 0;
  localparam int CFG_MERGE_LSB = 1;
  localparam int CFG_DECAP_LSB = 3;
  localparam int CFG_WIDTH = 5;
  localparam int CTL_WIDTH = 5;
  localparam int CTL_FLAG_BIT = 5;
  localparam int CTL_LEVEL_BIT = 6;
  localparam int STATUS_WIDTH = 4;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [4:0] RST_CONFIG = 5'h00;
  localparam logic [15:0] RST_START = 16'h0000;
  localparam logic [15:0] RST_MODULO = 16'h0000;
  localparam logic [15:0] RST_MATCH = 16'h0000;
  localparam logic [15:0] MATCH_ZERO = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Bit 4 irq enable, 3 mode_sel_b, 2 mode_sel_a, 1 level_sel_b, 0 level_sel_a
  typedef struct packed {
    logic channel_irq_enable;
    logic mode_sel_b;
    logic mode_sel_a;
    logic level_sel_b;
    logic level_sel_a;
  } tco_chctl_t;

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_OCMP,
    MODE_EDGE_ALIGNED_PWM,
    MODE_CENTER_ALIGNED_PWM,
    MODE_PAIR
  } tco_mode_t;

  typedef struct packed {
    logic out;
    logic drive;
    logic flag;
  } tco_chres_t;

endpackage

// ===== hw/tco_pair_eval.sv
// Next output level, drive and match flag for one even/odd channel pair
`timescale 1ns/10ps
module tco_pair_eval (
  input wire logic center_align_select,
  input wire logic pair_merge_enable,
  input wire logic dual_edge_capture_enable,
  input wire logic [15:0] cnt_value,
  input wire logic cnt_down,
  input wire logic cnt_reload,
  input wire logic [15:0] counter_start_value,
  input wire logic [15:0] modulo_value,
  input wire tco_pkg::tco_chctl_t even_ctl,
  input wire tco_pkg::tco_chctl_t odd_ctl,
  input wire logic [15:0] even_match,
  input wire logic [15:0] odd_match,
  input wire logic [1:0] cur_out,
  output logic [1:0] nxt_out,
  output logic [1:0] drive,
  output logic [1:0] set_flag
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic tco_pkg::tco_mode_t sel_mode(input tco_pkg::tco_chctl_t ctl);
    tco_pkg::tco_mode_t m;
    m = tco_pkg::MODE_NONE;
    if (dual_edge_capture_enable)
      m = tco_pkg::MODE_NONE;
    else if (center_align_select && !pair_merge_enable)
      m = tco_pkg::MODE_CENTER_ALIGNED_PWM;
    else if (pair_merge_enable && !center_align_select)
      m = tco_pkg::MODE_PAIR;
    else if (!pair_merge_enable && ctl.mode_sel_b)
      m = tco_pkg::MODE_EDGE_ALIGNED_PWM;
    else if (!pair_merge_enable && ctl.mode_sel_a)
      m = tco_pkg::MODE_OCMP;
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Single channel modes
  // ----------------------------------------------------------------
  function automatic tco_pkg::tco_chres_t eval_single(input tco_pkg::tco_mode_t m,
      input tco_pkg::tco_chctl_t ctl, input logic [15:0] cv, input logic cur);
    tco_pkg::tco_chres_t r;
    logic hit;
    logic act;
    logic zero;
    logic full;
    hit = (cnt_value == cv);
    // Active level is high for 1:0 and low for X:1
    act = cur ^ ctl.level_sel_a;
    r.out = cur;
    r.flag = 1'b0;
    zero = 1'b0;
    full = 1'b0;
    // Released pin keeps its last level so a later enable starts clean
    r.drive = (ctl.level_sel_b | ctl.level_sel_a);
    case (m)
      tco_pkg::MODE_OCMP:
      begin
        r.flag = hit;
        if (hit)
        begin
          case ({ctl.level_sel_b, ctl.level_sel_a})
            2'h1: r.out = ~cur;
            2'h2: r.out = 1'b0;
            2'h3: r.out = 1'b1;
            default: r.out = cur;
          endcase
        end
      end
      tco_pkg::MODE_EDGE_ALIGNED_PWM:
      begin
        // Period and width follow from the shared counter span
        zero = (cv == tco_pkg::MATCH_ZERO) || (cv == counter_start_value);
        full = (cv > modulo_value) || (counter_start_value > cv);
        if (zero)
          act = 1'b0;
        else if (full)
          act = 1'b1;
        else if (hit)
          act = 1'b0;
        else if (cnt_reload)
          act = 1'b1;
        r.out = act ^ ctl.level_sel_a;
        r.flag = hit && !zero && !full;
      end
      tco_pkg::MODE_CENTER_ALIGNED_PWM:
      begin
        zero = (cv == tco_pkg::MATCH_ZERO) || cv[15];
        full = !cv[15] && (cv >= modulo_value) && (modulo_value != tco_pkg::MATCH_ZERO);
        if (zero)
          act = 1'b0;
        else if (full)
          act = 1'b1;
        else if (hit)
          act = cnt_down;
        r.out = act ^ ctl.level_sel_a;
        r.flag = hit && !zero && !full;
      end
      default:
      begin
        r.drive = 1'b0;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pair evaluation
  // ----------------------------------------------------------------
  tco_pkg::tco_mode_t mode_even;
  tco_pkg::tco_mode_t mode_odd;
  tco_pkg::tco_chres_t res_even;
  tco_pkg::tco_chres_t res_odd;
  logic pair_act;
  logic pair_out;

  always_comb
  begin
    mode_even = sel_mode(even_ctl);
    mode_odd = sel_mode(odd_ctl);
    res_even = eval_single(mode_even, even_ctl, even_match, cur_out[0]);
    res_odd = eval_single(mode_odd, odd_ctl, odd_match, cur_out[1]);
    // Later assignments win: odd match over even match over period start
    pair_act = cur_out[0] ^ even_ctl.level_sel_a;
    if (cnt_value == counter_start_value)
      pair_act = 1'b0;
    if (cnt_value == even_match)
      pair_act = 1'b1;
    if (cnt_value == odd_match)
      pair_act = 1'b0;
    pair_out = pair_act ^ even_ctl.level_sel_a;
    if (mode_even == tco_pkg::MODE_PAIR)
    begin
      nxt_out = {pair_out, pair_out};
      drive = {(odd_ctl.level_sel_b | odd_ctl.level_sel_a),
               (even_ctl.level_sel_b | even_ctl.level_sel_a)};
      set_flag = {(cnt_value == odd_match), (cnt_value == even_match)};
    end
    else
    begin
      nxt_out = {res_odd.out, res_even.out};
      drive = {res_odd.drive, res_even.drive};
      set_flag = {res_odd.flag, res_even.flag};
    end
  end

endmodule

// ===== test/tco_channels_asserts.sv
// Bus and pin checks bound to the timer channel output block
`timescale 1ns/10ps
module tco_channels_asserts (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [3:0] CH_OUT,
  input wire logic [3:0] CH_OE_N,
  input wire logic [3:0] CH_IRQ
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence

  a_reset_quiet: assert property ($rose(RST_N) |-> CH_OE_N == 4'hf && CH_OUT == 4'h0 && CH_IRQ == 4'h0)
    else $error("channel pins not idle after reset");
  a_write_answer: assert property (wr_taken |-> ##2 S_AXI_BVALID)
    else $error("write response not on time");
  a_write_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write ready while response pending");
  a_ready_back: assert property (S_AXI_BVALID && S_AXI_BREADY |-> ##[1:2] (S_AXI_AWREADY && S_AXI_WREADY))
    else $error("write ready did not return");
  a_read_answer: assert property (rd_taken |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read data not on time");
  a_read_cleared: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read valid stayed after handshake");
  a_bad_read: assert property (rd_taken and (S_AXI_ARADDR >= 8'h30) |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  // Released pins must keep their level so a later re-enable is glitch free
  a_released_hold: assert property ($past(RST_N) |-> ((CH_OUT ^ $past(CH_OUT)) & CH_OE_N & $past(CH_OE_N)) == 4'h0)
    else $error("released channel level changed");
endmodule

bind tco_channels tco_channels_asserts tco_channels_asserts_i (.*);

// ===== test/tco_load.sv
// Load on the channel pins: pull-down per pin and high-time counters
`timescale 1ns/10ps
module tco_load (
  input wire logic MCLK,
  input wire logic clr,
  input wire logic [3:0] CH_OUT,
  input wire logic [3:0] CH_OE_N,
  output logic [3:0] pin,
  output int hc [2]
);
  // Pull-down: a released pin settles low whatever level is held
  assign pin = CH_OUT & ~CH_OE_N;
  always @(posedge MCLK)
  begin
    for (int i = 0; i < 2; i++)
      hc[i] <= clr ? 0 : hc[i] + int'(pin[i] === 1'b1);
  end
endmodule

// ===== test/tco_channels_tb.sv
// Self-checking bench for the timer channel output block
`timescale 1ns/10ps
module tco_channels_tb;
  typedef struct {
    logic [7:0] cfg, c0, c1, h0, h1;
    logic [15:0] st, md, m0, m1;
    logic [1:0] fl;
  } tco_tcase_t;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [15:0] CNT_VALUE = 16'h0;
  logic CNT_DOWN = 1'b0;
  logic CNT_RELOAD = 1'b0;
  logic [7:0] S_AXI_AWADDR = 8'h0, S_AXI_ARADDR = 8'h0;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'h0;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_ARVALID = 1'b0;
  logic S_AXI_BREADY = 1'b1, S_AXI_RREADY = 1'b1;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic [3:0] CH_OUT, CH_OE_N, CH_IRQ, pin;
  logic clr = 1'b0, run = 1'b0, center = 1'b0;
  logic [15:0] cnt_start = 16'h0, cnt_mod = 16'h0;
  int hc [2];
  int fail_count = 0;
  int check_count = 0;
  int p;
  tco_tcase_t tc;
  // High times are per period; ch1 unused outside pair mode stays released
  tco_tcase_t cases [17] = '{
    '{8'h0, 8'h1a, 8'h0, 8'h4, 8'h0, 16'h0, 16'h9, 16'h4, 16'h0, 2'h1},
    '{8'h0, 8'h19, 8'h0, 8'h6, 8'h0, 16'h0, 16'h9, 16'h4, 16'h0, 2'h1},
    '{8'h0, 8'h1a, 8'h0, 8'h0, 8'h0, 16'h0, 16'h9, 16'h0, 16'h0, 2'h0},
    '{8'h0, 8'h1a, 8'h0, 8'ha, 8'h0, 16'h0, 16'h9, 16'ha, 16'h0, 2'h0},
    '{8'h0, 8'h1a, 8'h0, 8'h8, 8'h0, 16'h2, 16'h9, 16'h1, 16'h0, 2'h0},
    '{8'h0, 8'h1a, 8'h0, 8'h3, 8'h0, 16'h2, 16'h9, 16'h5, 16'h0, 2'h1},
    '{8'h1, 8'h12, 8'h0, 8'h6, 8'h0, 16'h0, 16'h8, 16'h3, 16'h0, 2'h1},
    '{8'h1, 8'h11, 8'h0, 8'ha, 8'h0, 16'h0, 16'h8, 16'h3, 16'h0, 2'h1},
    '{8'h1, 8'h12, 8'h0, 8'h0, 8'h0, 16'h0, 16'h8, 16'h8003, 16'h0, 2'h0},
    '{8'h1, 8'h12, 8'h0, 8'h10, 8'h0, 16'h0, 16'h8, 16'h8, 16'h0, 2'h0},
    '{8'h0, 8'h15, 8'h0, 8'h5, 8'h0, 16'h0, 16'h9, 16'h3, 16'h0, 2'h1},
    '{8'h0, 8'h16, 8'h0, 8'h0, 8'h0, 16'h0, 16'h9, 16'h3, 16'h0, 2'h1},
    '{8'h0, 8'h14, 8'h0, 8'h0, 8'h0, 16'h0, 16'h9, 16'h3, 16'h0, 2'h1},
    '{8'h2, 8'h12, 8'h12, 8'h3, 8'h3, 16'h0, 16'h9, 16'h2, 16'h5, 2'h3},
    '{8'h2, 8'h11, 8'h0, 8'h7, 8'h0, 16'h0, 16'h9, 16'h2, 16'h5, 2'h3},
    '{8'h8, 8'h14, 8'h0, 8'h0, 8'h0, 16'h0, 16'h9, 16'h3, 16'h0, 2'h0},
    '{8'h0, 8'h17, 8'h0, 8'ha, 8'h0, 16'h0, 16'h9, 16'h3, 16'h0, 2'h1}
  };

  tco_channels tco_channels_i (.*);
  tco_load tco_load_i (.*);

  always #10 MCLK = ~MCLK;

  // Counter stand-in; center mode only with a legal modulo
  always @(posedge MCLK)
  begin
    CNT_RELOAD <= run && !center && CNT_VALUE == cnt_mod;
    if (!run)
      CNT_VALUE <= cnt_start;
    else if (!center)
      CNT_VALUE <= (CNT_VALUE == cnt_mod) ? cnt_start : CNT_VALUE + 16'h1;
    else
      CNT_VALUE <= (CNT_DOWN || CNT_VALUE == cnt_mod) ? CNT_VALUE - 16'h1 : CNT_VALUE + 16'h1;
    CNT_DOWN <= run && center && (CNT_DOWN ? CNT_VALUE != cnt_start + 16'h1 : CNT_VALUE == cnt_mod);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wait_ok(input int n);
    if (n >= 200)
    begin
      chk("handshake wait", 32'h0, 32'h1);
      report_and_stop();
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                           input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    do
    begin
      @(posedge MCLK);
      n++;
      if (S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY)
        S_AXI_WVALID <= 1'b0;
    end
    while (!S_AXI_BVALID && n < 200);
    wait_ok(n);
    chk("write resp", {30'h0, er}, {30'h0, S_AXI_BRESP});
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do
    begin
      @(posedge MCLK);
      n++;
      if (S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'b0;
    end
    while (!S_AXI_RVALID && n < 200);
    wait_ok(n);
    chk("read data", e, S_AXI_RDATA);
    chk("read resp", {30'h0, er}, {30'h0, S_AXI_RRESP});
  endtask

  initial
  begin
    repeat (20) @(posedge MCLK);
    RST_N <= 1'b1;
    axi_read(8'h00, 32'h0);
    axi_read(8'h30, 32'h0, 2'h2);
    axi_write(8'h30, 32'h5, 4'hf, 2'h2);
    axi_write(8'h14, 32'h1234);
    axi_write(8'h14, 32'hff56, 4'h1);
    axi_read(8'h14, 32'h1256);
    foreach (cases[k])
    begin
      tc = cases[k];
      p = tc.cfg[0] ? 2 * (tc.md - tc.st) : tc.md - tc.st + 1;
      run <= 1'b0;
      cnt_start <= tc.st;
      cnt_mod <= tc.md;
      center <= tc.cfg[0];
      axi_write(8'h00, {24'h0, tc.cfg});
      axi_write(8'h04, {16'h0, tc.st});
      axi_write(8'h08, {16'h0, tc.md});
      axi_write(8'h10, {24'h0, tc.c0});
      axi_write(8'h14, {16'h0, tc.m0});
      axi_write(8'h18, {24'h0, tc.c1});
      axi_write(8'h1c, {16'h0, tc.m1});
      axi_write(8'h0c, 32'hf);
      run <= 1'b1;
      // Two periods of settling so the window sees only steady waveforms
      repeat (2 * p) @(posedge MCLK);
      clr <= 1'b1;
      @(posedge MCLK);
      clr <= 1'b0;
      repeat (2 * p) @(posedge MCLK);
      #1;
      chk("ch0 high time", 2 * tc.h0, hc[0]);
      chk("ch1 high time", 2 * tc.h1, hc[1]);
      chk("irq", {30'h0, {tc.c1[4], tc.c0[4]} & tc.fl}, {28'h0, CH_IRQ});
      chk("release", {30'h0, tc.c1[1:0] == 2'h0, tc.c0[1:0] == 2'h0}, {30'h0, CH_OE_N[1:0]});
      axi_read(8'h0c, {30'h0, tc.fl});
    end
    run <= 1'b0;
    axi_write(8'h10, 32'h15);
    repeat (4) @(posedge MCLK);
    chk("held level", 32'h1, {31'h0, CH_OUT[0]});
    report_and_stop();
  end
endmodule
